/* rtl/fm_alert_ctl.sv */
// fm_alert_ctl: latched alarm, alert response slave and fan override
// assumes: conversion engine gives same-clock start/done pulses and result;
// link and pin inputs are asynchronous and pass fm_sync first
`timescale 1ns/10ps
module fm_alert_ctl #(
	parameter logic [7:0] MFG_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3C  // arbitrary value
) (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       smb_clk_i,
	input  wire logic       smb_data_i,
	output logic            smb_data_o,
	output logic            smb_data_oe,
	output logic            alert_n_o,
	output logic            alert_n_oe,
	input  wire logic       gp_pin_one,
	input  wire logic       gp_pin_two,
	input  wire logic [6:0] slave_addr_i,
	input  wire logic       conv_start,
	input  wire logic       conv_done,
	input  wire logic [7:0] conv_result,
	input  wire logic       diode_fault_det,
	input  wire logic       diode_tiny_diff,
	output logic            critical_thermostat_out,
	output logic [7:0]      temp_data,
	output logic [7:0]      fan_level
);
	fm_pkg::fm_state_s st_q;
	fm_pkg::fm_state_s st_d;
	fm_pkg::fm_pins_s  pins_raw;
	fm_pkg::fm_pins_s  pin;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_c;
	logic              stop_c;
	logic              gp_edge;
	logic [7:0]        shift_in;
	logic [7:0]        conv_res;
	logic              hi_ex;
	logic              lo_ex;
	logic              ara_done;
	logic              wr_hi;
	logic              wr_duty;
	logic              fan_force;

	// register read mux, pointer selects the byte
	function automatic logic [7:0] rd_byte(input fm_pkg::fm_state_s s);
		case (s.ptr)
			fm_pkg::CMD_RTEMP: rd_byte = s.temp;
			fm_pkg::CMD_RSTAT: rd_byte = {3'h0, s.hi_flag, s.lo_flag, s.fault, s.gp_p};
			fm_pkg::CMD_RCFG:  rd_byte = s.cfg;
			fm_pkg::CMD_RHI:   rd_byte = s.hi;
			fm_pkg::CMD_RLOW:  rd_byte = s.lo;
			fm_pkg::CMD_RCRIT: rd_byte = s.crit;
			fm_pkg::CMD_RDUTY: rd_byte = s.duty;
			fm_pkg::CMD_RMFG:  rd_byte = MFG_CODE;
			fm_pkg::CMD_RDEV:  rd_byte = DEV_CODE;
			default:           rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	// all pins cross together
	assign pins_raw = '{scl: smb_clk_i, sda: smb_data_i, gp2: gp_pin_two, gp1: gp_pin_one,
		addr: slave_addr_i};

	fm_sync fm_sync_inst (
		.core_clk (core_clk),
		.rstn     (rstn),
		.din      (pins_raw),
		.dout     (pin)
	);

	// link events seen on the core clock, using the stable stage only
	assign scl_rise = pin.scl & ~st_q.scl_p;
	assign scl_fall = ~pin.scl & st_q.scl_p;
	assign start_c  = pin.scl & st_q.scl_p & st_q.sda_p & ~pin.sda;
	assign stop_c   = pin.scl & st_q.scl_p & ~st_q.sda_p & pin.sda;
	assign shift_in = {st_q.shift[6:0], pin.sda};

	// either edge on either general-purpose pin; gp_ok waits out the synchroniser
	// so that a pin idling high is not taken for an edge after reset
	assign gp_edge = st_q.gp_ok[2] & ((pin.gp1 ^ st_q.gp_p[0]) | (pin.gp2 ^ st_q.gp_p[1]));

	// a faulty diode replaces the result with the top code
	assign conv_res = st_q.fault ? fm_pkg::FAULT_CODE : conv_result;
	assign hi_ex    = fm_pkg::fm_sgt(conv_res, st_q.hi);
	assign lo_ex    = fm_pkg::fm_sgt(st_q.lo, conv_res);

	// next state: conversion, link, then alert latch so set beats clear
	always_comb
	begin
		st_d     = st_q;
		ara_done = 1'b0;
		wr_hi    = 1'b0;
		wr_duty  = 1'b0;
		st_d.scl_p = pin.scl;
		st_d.sda_p = pin.sda;
		st_d.gp_p  = {pin.gp2, pin.gp1};
		st_d.gp_ok = {st_q.gp_ok[1:0], 1'b1};

		// fault check at the start of every conversion
		if (conv_start)
			st_d.fault = diode_fault_det | diode_tiny_diff;

		// once per completed conversion, never stalled by the alert
		if (conv_done)
		begin
			st_d.temp       = conv_res;
			st_d.hi_flag    = hi_ex;
			st_d.lo_flag    = lo_ex;
			st_d.crit_latch = fm_pkg::fm_sgt(conv_res, st_q.crit);
			if (hi_ex)
				st_d.hi_arm = 1'b0;
			if (lo_ex)
				st_d.lo_arm = 1'b0;
		end

		// byte-level slave on the two-wire link
		case (st_q.phase)
			fm_pkg::PH_ADDR:
			begin
				if (scl_rise)
				begin
					st_d.shift = shift_in;
					st_d.bits  = st_q.bits + 4'h1;
					if (st_q.bits == fm_pkg::LAST_BIT)
					begin
						st_d.rw  = pin.sda;
						st_d.ara = 1'b0;
						if (st_q.shift[6:0] == pin.addr)
							st_d.phase = fm_pkg::PH_ACKD;
						else if (st_q.shift[6:0] == fm_pkg::ARA_ADDR && pin.sda && st_q.alert)
						begin
							st_d.ara   = 1'b1;
							st_d.phase = fm_pkg::PH_ACKD;
						end
						else
							st_d.phase = fm_pkg::PH_IDLE;
					end
				end
			end
			fm_pkg::PH_ACKD:
			begin
				if (scl_fall)
				begin
					st_d.sda_oe = 1'b1;
					st_d.phase  = fm_pkg::PH_ACKH;
				end
			end
			fm_pkg::PH_ACKH:
			begin
				if (scl_fall)
				begin
					st_d.bits = 4'h0;
					if (st_q.rw)
					begin
						// response byte carries our address with bit 0 high
						st_d.shift  = st_q.ara ? {pin.addr, 1'b1} : rd_byte(st_q);
						st_d.sda_oe = ~st_d.shift[7];
						st_d.phase  = fm_pkg::PH_TX;
					end
					else
					begin
						st_d.sda_oe = 1'b0;
						st_d.phase  = fm_pkg::PH_RX;
					end
				end
			end
			fm_pkg::PH_RX:
			begin
				if (scl_rise)
				begin
					st_d.shift = shift_in;
					st_d.bits  = st_q.bits + 4'h1;
					if (st_q.bits == fm_pkg::LAST_BIT)
					begin
						st_d.phase = fm_pkg::PH_ACKD;
						st_d.bits  = 4'h0;
						if (!st_q.wr_data)
						begin
							st_d.ptr     = shift_in;
							st_d.wr_data = 1'b1;
						end
						else
						begin
							// rewriting a limit re-arms only that limit
							case (st_q.ptr)
								fm_pkg::CMD_WCFG:  st_d.cfg = shift_in;
								fm_pkg::CMD_WHI:
								begin
									st_d.hi     = shift_in;
									st_d.hi_arm = 1'b1;
									wr_hi       = 1'b1;
								end
								fm_pkg::CMD_WLOW:
								begin
									st_d.lo     = shift_in;
									st_d.lo_arm = 1'b1;
								end
								fm_pkg::CMD_WCRIT: st_d.crit = shift_in;
								fm_pkg::CMD_WDUTY:
								begin
									st_d.duty = shift_in;
									wr_duty   = 1'b1;
								end
								default:           st_d.cfg = st_q.cfg;
							endcase
						end
					end
				end
			end
			fm_pkg::PH_TX:
			begin
				if (scl_rise)
				begin
					st_d.bits = st_q.bits + 4'h1;
					// released a one but the line reads low: a lower address won
					if (st_q.ara && !st_q.sda_oe && !pin.sda)
						st_d.phase = fm_pkg::PH_IDLE;
					else if (st_q.bits == fm_pkg::LAST_BIT)
					begin
						ara_done   = st_q.ara;
						st_d.phase = fm_pkg::PH_TXACK;
					end
				end
				else if (scl_fall)
				begin
					st_d.shift  = {st_q.shift[6:0], 1'b0};
					st_d.sda_oe = ~st_q.shift[6];
				end
			end
			fm_pkg::PH_TXACK:
			begin
				// master acknowledge is not needed; release and wait
				if (scl_fall)
				begin
					st_d.sda_oe = 1'b0;
					st_d.phase  = fm_pkg::PH_IDLE;
				end
			end
			default:
			begin
				st_d.phase = fm_pkg::PH_IDLE;
			end
		endcase

		// start and stop override any phase
		if (start_c)
		begin
			st_d.phase   = fm_pkg::PH_ADDR;
			st_d.bits    = 4'h0;
			st_d.sda_oe  = 1'b0;
			st_d.wr_data = 1'b0;
		end
		else if (stop_c)
		begin
			st_d.phase  = fm_pkg::PH_IDLE;
			st_d.sda_oe = 1'b0;
		end

		// alert latch: response clear first, then any new event wins
		if (ara_done)
			st_d.alert = 1'b0;
		if (conv_done && ((hi_ex && st_q.hi_arm) || (lo_ex && st_q.lo_arm) || st_q.fault))
			st_d.alert = 1'b1;
		if (gp_edge)
			st_d.alert = 1'b1;

		// critical compare feeds its own output and the fan override, never the alert
		st_d.crit_out = st_q.crit_latch;
		st_d.alert_oe = st_q.alert & ~st_q.cfg[fm_pkg::CFG_MASK];
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st_q <= fm_pkg::ST_RST;
		else
			st_q <= st_d;
	end

	// override follows the latch directly, so it ends when the latch does
	assign fan_force = st_q.cfg[fm_pkg::CFG_FANON] & st_q.crit_latch;

	fm_fan_drive fm_fan_drive_inst (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.force_full (fan_force),
		.duty       (st_q.duty),
		.fan_level  (fan_level)
	);

	// open-drain pins only ever pull low
	assign smb_data_o              = 1'b0;
	assign alert_n_o               = 1'b0;
	assign smb_data_oe             = st_q.sda_oe;
	assign alert_n_oe              = st_q.alert_oe;
	assign critical_thermostat_out = st_q.crit_out;
	assign temp_data               = st_q.temp;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_fault_conv;
		conv_done && st_q.fault;
	endsequence

	sequence s_forced;
		st_q.cfg[fm_pkg::CFG_FANON] && st_q.crit_latch;
	endsequence

	a_crit_no_alert: assert property (conv_done && !st_q.alert && !st_q.fault && !gp_edge && !ara_done
		&& !(hi_ex && st_q.hi_arm) && !(lo_ex && st_q.lo_arm) |=> !st_q.alert)
		else $error("alert set without a limit, fault or pin event");
	a_fan_forced: assert property (s_forced |=> fan_level == fm_pkg::FAN_FULL)
		else $error("fan not forced full by critical override");
	a_fan_revert: assert property (!fan_force |=> fan_level == $past(st_q.duty))
		else $error("fan level not back at programmed duty");
	a_duty_kept: assert property (s_forced ##0 !wr_duty |=> $stable(st_q.duty))
		else $error("override altered the stored duty");
	a_fault_sample: assert property (conv_start |=>
		st_q.fault == $past(diode_fault_det || diode_tiny_diff))
		else $error("fault flag not taken at conversion start");
	a_fault_alert: assert property (s_fault_conv |=> st_q.temp == fm_pkg::FAULT_CODE && st_q.alert
		##1 (alert_n_oe || st_q.cfg[fm_pkg::CFG_MASK]))
		else $error("fault did not give top code and alert");
	a_latch_hold: assert property (st_q.alert && !ara_done |=> st_q.alert)
		else $error("alert latch cleared without response read");
	a_gp_alert: assert property (gp_edge |=> st_q.alert ##1 (alert_n_oe || st_q.cfg[fm_pkg::CFG_MASK]))
		else $error("pin edge did not raise alert");
	a_limit_quiet: assert property (!st_q.hi_arm && !wr_hi |=> !st_q.hi_arm)
		else $error("upper limit re-armed without rewrite");
	a_ara_byte: assert property (st_q.phase == fm_pkg::PH_ACKH && st_q.rw && st_q.ara && scl_fall
		|=> st_q.shift == {pin.addr, 1'b1})
		else $error("response byte is not own address with bit 0 high");
endmodule : fm_alert_ctl

/* rtl/fm_fan_drive.sv */
// fm_fan_drive: fan level selector with the critical override
// assumes: duty and force come from the core clock domain
`timescale 1ns/10ps
module fm_fan_drive (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       force_full,
	input  wire logic [7:0] duty,
	output logic [7:0]      fan_level
);
	fm_pkg::fm_fan_s st_q;
	fm_pkg::fm_fan_s st_d;

	// override never touches the stored duty, only the output
	always_comb
	begin
		st_d.level = force_full ? fm_pkg::FAN_FULL : duty;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign fan_level = st_q.level;
endmodule : fm_fan_drive

/* rtl/fm_pkg.sv */
// fm_pkg: constants, carriers and state types of the thermal alert block
// assumes: one core clock; pins reach the logic only through fm_sync
package fm_pkg;
	// two-wire link addressing and command pointer
	localparam logic [6:0] ARA_ADDR   = 7'h0C;
	localparam logic [7:0] PTR_RST    = 8'h01;
	localparam logic [3:0] LAST_BIT   = 4'h7;

	// command codes
	localparam logic [7:0] CMD_RTEMP  = 8'h01;
	localparam logic [7:0] CMD_RSTAT  = 8'h02;
	localparam logic [7:0] CMD_RCFG   = 8'h03;
	localparam logic [7:0] CMD_RHI    = 8'h07;
	localparam logic [7:0] CMD_RLOW   = 8'h08;
	localparam logic [7:0] CMD_WCFG   = 8'h09;
	localparam logic [7:0] CMD_WHI    = 8'h0D;
	localparam logic [7:0] CMD_WLOW   = 8'h0E;
	localparam logic [7:0] CMD_RCRIT  = 8'h10;
	localparam logic [7:0] CMD_RDUTY  = 8'h13;
	localparam logic [7:0] CMD_WCRIT  = 8'h18;
	localparam logic [7:0] CMD_WDUTY  = 8'h1B;
	localparam logic [7:0] CMD_RMFG   = 8'hFE;
	localparam logic [7:0] CMD_RDEV   = 8'hFF;

	// reset values and fixed codes
	localparam logic [7:0] CFG_RST    = 8'h02;
	localparam logic [7:0] HI_RST     = 8'h7F;
	localparam logic [7:0] LO_RST     = 8'hC9;
	localparam logic [7:0] CRIT_RST   = 8'h64;
	localparam logic [7:0] FAULT_CODE = 8'h7F;
	localparam logic [7:0] FAN_FULL   = 8'hFF;

	// field positions in the configuration byte
	localparam int CFG_MASK  = 7;
	localparam int CFG_FANON = 2;

	typedef enum logic [6:0] {
		PH_IDLE  = 7'h01,
		PH_ADDR  = 7'h02,
		PH_ACKD  = 7'h04,
		PH_ACKH  = 7'h08,
		PH_RX    = 7'h10,
		PH_TX    = 7'h20,
		PH_TXACK = 7'h40
	} fm_phase_e;

	// pins that cross into the core clock together
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       gp2;
		logic       gp1;
		logic [6:0] addr;
	} fm_pins_s;

	typedef struct packed {
		fm_pins_s meta;
		fm_pins_s stable;
	} fm_sync_s;

	typedef struct packed {
		logic [7:0] level;
	} fm_fan_s;

	typedef struct packed {
		fm_phase_e  phase;
		logic       scl_p;
		logic       sda_p;
		logic [3:0] bits;
		logic [7:0] shift;
		logic       rw;
		logic       ara;
		logic       wr_data;
		logic [7:0] ptr;
		logic [7:0] cfg;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] crit;
		logic [7:0] duty;
		logic [7:0] temp;
		logic       fault;
		logic       hi_arm;
		logic       lo_arm;
		logic       hi_flag;
		logic       lo_flag;
		logic       alert;
		logic       crit_latch;
		logic [1:0] gp_p;
		logic [2:0] gp_ok; // shifts in ones after reset, top bit arms the pin edge detector
		logic       sda_oe;
		logic       alert_oe;
		logic       crit_out;
	} fm_state_s;

	localparam fm_state_s ST_RST = '{phase: PH_IDLE, ptr: PTR_RST, cfg: CFG_RST, hi: HI_RST,
		lo: LO_RST, crit: CRIT_RST, hi_arm: 1'b1, lo_arm: 1'b1, default: '0};

	// signed two's-complement greater-than on temperature codes
	function automatic logic fm_sgt(input logic [7:0] a, input logic [7:0] b);
		return $signed(a) > $signed(b);
	endfunction : fm_sgt
endpackage : fm_pkg

/* rtl/fm_sync.sv */
// fm_sync: two-flop synchroniser for every pin of the block
// assumes: pins are asynchronous to core_clk; only the second stage is read
`timescale 1ns/10ps
module fm_sync (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire fm_pkg::fm_pins_s din,
	output fm_pkg::fm_pins_s      dout
);
	fm_pkg::fm_sync_s st_q;
	fm_pkg::fm_sync_s st_d;

	// first stage feeds only the second
	always_comb
	begin
		st_d.meta   = din;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign dout = st_q.stable;
endmodule : fm_sync

/* verif/fm_host_model.sv */
// fm_host_model: behavioural two-wire host with one rival alert slave
// assumes: bench resolves the wired-and data line and returns it on sda
`timescale 1ns/10ps
module fm_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic core_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      host_low,
	output logic      rival_low
);
	// link clock idles high and stands still between frames
	initial
	begin
		scl       = 1'b1;
		host_low  = 1'b0;
		rival_low = 1'b0;
	end

	// quarter of the 160 ns link period, moves on core falling edges
	task automatic q_wait;
		repeat (5) @(negedge core_clk);
	endtask : q_wait

	task automatic put_bit(input logic b);
		host_low = ~b;
		q_wait();
		scl = 1'b1;
		q_wait();
		q_wait();
		scl = 1'b0;
		q_wait();
	endtask : put_bit

	// pull asks the rival slave to hold the line low for this bit
	task automatic get_bit(input logic pull, output logic b);
		host_low  = 1'b0;
		rival_low = pull;
		q_wait();
		scl = 1'b1;
		q_wait();
		b = sda;
		q_wait();
		scl = 1'b0;
		rival_low = 1'b0;
		q_wait();
	endtask : get_bit

	// also serves as repeated start: line released a full quarter first
	task automatic start;
		host_low = 1'b0;
		q_wait();
		scl = 1'b1;
		q_wait();
		host_low = 1'b1;
		q_wait();
		scl = 1'b0;
		q_wait();
	endtask : start

	task automatic stop;
		host_low = 1'b1;
		q_wait();
		scl = 1'b1;
		q_wait();
		host_low = 1'b0;
		q_wait();
	endtask : stop

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic x;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i]);
		get_bit(1'b0, x);
		ack = ~x;
	endtask : send_byte

	// host always ends a read with a nack
	task automatic recv_byte(input logic [7:0] rv, input logic ron, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			get_bit(ron & ~rv[i], d[i]);
		put_bit(1'b1);
	endtask : recv_byte

	task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
		logic a;
		start();
		send_byte({DEV_ADDR, 1'b0}, a);
		send_byte(cmd, a);
		send_byte(data, a);
		stop();
	endtask : write_reg

	task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d);
		logic a;
		start();
		send_byte({DEV_ADDR, 1'b0}, a);
		send_byte(cmd, a);
		start();
		send_byte({DEV_ADDR, 1'b1}, a);
		recv_byte(8'h00, 1'b0, d);
		stop();
	endtask : read_reg

	task automatic recv_only(output logic [7:0] d);
		logic a;
		start();
		send_byte({DEV_ADDR, 1'b1}, a);
		recv_byte(8'h00, 1'b0, d);
		stop();
	endtask : recv_only

	// receive byte to the alert response address, rival may answer too
	task automatic ara(input logic ron, input logic [6:0] raddr, output logic ack, output logic [7:0] d);
		start();
		send_byte({fm_pkg::ARA_ADDR, 1'b1}, ack);
		recv_byte({raddr, 1'b1}, ron, d);
		stop();
	endtask : ara
endmodule : fm_host_model

/* verif/test_thermal_alert_interrupt_logic.sv */
// test_thermal_alert_interrupt_logic: directed bench for the alert block
// assumes: fm_host_model on the link, bench plays the conversion engine
`timescale 1ns/10ps
`define check_eq(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("Error at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module test_thermal_alert_interrupt_logic;
	localparam logic [6:0] OWN_ADDR = 7'h2A;
	localparam logic [6:0] RIV_ADDR = 7'h18;
	logic       core_clk, rstn, gp1, gp2, conv_start, conv_done, det, tiny;
	logic       scl, host_low, rival_low, sda_oe, sda_o, alert_o, alert_oe, crit, ack;
	logic [7:0] result, temp, fan, rd;
	int         comparisons, n_mismatch, cycles;
	wire        sda = ~(host_low | rival_low | sda_oe);

	fm_alert_ctl fm_alert_ctl_inst (.core_clk(core_clk), .rstn(rstn), .smb_clk_i(scl), .smb_data_i(sda),
		.smb_data_o(sda_o), .smb_data_oe(sda_oe), .alert_n_o(alert_o), .alert_n_oe(alert_oe),
		.gp_pin_one(gp1), .gp_pin_two(gp2), .slave_addr_i(OWN_ADDR), .conv_start(conv_start),
		.conv_done(conv_done), .conv_result(result), .diode_fault_det(det), .diode_tiny_diff(tiny),
		.critical_thermostat_out(crit), .temp_data(temp), .fan_level(fan));
	fm_host_model #(.DEV_ADDR(OWN_ADDR)) fm_host_model_inst (.core_clk(core_clk), .sda(sda), .scl(scl),
		.host_low(host_low), .rival_low(rival_low));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ceiling well above the roughly 15500 cycles the tests need
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// one conversion; detector level at start and at done given apart
	task automatic convert(input logic [7:0] res, input logic f_start, input logic f_done);
		det = f_start;
		@(negedge core_clk) conv_start = 1'b1;
		@(negedge core_clk) conv_start = 1'b0;
		det = f_done;
		repeat (3) @(negedge core_clk);
		result = res;
		conv_done = 1'b1;
		@(negedge core_clk) conv_done = 1'b0;
		repeat (6) @(negedge core_clk);
	endtask : convert

	// alert response read, expects own or rival address and the pin after
	task automatic ara_chk(input logic ron, input logic exp_alert);
		fm_host_model_inst.ara(ron, RIV_ADDR, ack, rd);
		repeat (6) @(negedge core_clk);
		`check_eq(ack, 1'b1)
		`check_eq(rd, {(ron ? RIV_ADDR : OWN_ADDR), 1'b1})
		`check_eq(alert_oe, exp_alert)
	endtask : ara_chk

	initial
	begin
		rstn = 1'b0;
		{gp1, gp2, conv_start, conv_done, tiny} = '0;
		det = 1'b1;
		result = 8'h00;
		repeat (8) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		`check_eq(alert_oe, 1'b0)
		convert(8'h19, 1'b0, 1'b0);
		fm_host_model_inst.recv_only(rd);
		`check_eq(rd, 8'h19)
		`check_eq(alert_o, 1'b0)
		`check_eq(sda_o, 1'b0)
		$display("test power_on done");

		fm_host_model_inst.write_reg(fm_pkg::CMD_WHI, 8'h30);
		convert(8'h40, 1'b0, 1'b0);
		`check_eq(alert_oe, 1'b1)
		`check_eq(temp, 8'h40)
		ara_chk(1'b0, 1'b0);
		convert(8'h41, 1'b0, 1'b0);
		`check_eq(alert_oe, 1'b0)
		`check_eq(temp, 8'h41)
		fm_host_model_inst.write_reg(fm_pkg::CMD_WHI, 8'h30);
		convert(8'h40, 1'b0, 1'b0);
		`check_eq(alert_oe, 1'b1)
		ara_chk(1'b0, 1'b0);
		$display("test upper_limit done");

		fm_host_model_inst.write_reg(fm_pkg::CMD_WLOW, 8'h10);
		convert(8'h05, 1'b0, 1'b0);
		`check_eq(alert_oe, 1'b1)
		convert(8'h06, 1'b0, 1'b0);
		`check_eq(temp, 8'h06)
		ara_chk(1'b1, 1'b1);
		ara_chk(1'b0, 1'b0);
		fm_host_model_inst.ara(1'b0, RIV_ADDR, ack, rd);
		`check_eq(ack, 1'b0)
		$display("test lower_and_arbitration done");

		// rise and fall on each general-purpose pin
		for (int i = 0; i < 4; i++)
		begin
			if (i < 2)
				gp1 = ~gp1;
			else
				gp2 = ~gp2;
			repeat (8) @(negedge core_clk);
			`check_eq(alert_oe, 1'b1)
			ara_chk(1'b0, 1'b0);
		end
		$display("test pin_edges done");

		convert(8'h20, 1'b0, 1'b1);
		`check_eq(temp, 8'h20)
		`check_eq(alert_oe, 1'b0)
		convert(8'h20, 1'b1, 1'b1);
		`check_eq(temp, fm_pkg::FAULT_CODE)
		`check_eq(alert_oe, 1'b1)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RSTAT, rd);
		`check_eq(rd[2], 1'b1)
		ara_chk(1'b0, 1'b0);
		tiny = 1'b1;
		convert(8'h20, 1'b0, 1'b0);
		tiny = 1'b0;
		`check_eq(temp, fm_pkg::FAULT_CODE)
		convert(8'h20, 1'b0, 1'b0);
		`check_eq(temp, 8'h20)
		ara_chk(1'b0, 1'b0);
		$display("test diode_fault done");

		fm_host_model_inst.write_reg(fm_pkg::CMD_WHI, 8'h7F);
		fm_host_model_inst.write_reg(fm_pkg::CMD_WLOW, 8'hC9);
		fm_host_model_inst.write_reg(fm_pkg::CMD_WDUTY, 8'h40);
		fm_host_model_inst.write_reg(fm_pkg::CMD_WCFG, 8'h06);
		convert(8'h19, 1'b0, 1'b0);
		`check_eq(fan, 8'h40)
		convert(8'h70, 1'b0, 1'b0);
		`check_eq(crit, 1'b1)
		`check_eq(fan, fm_pkg::FAN_FULL)
		`check_eq(alert_oe, 1'b0)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RDUTY, rd);
		`check_eq(rd, 8'h40)
		convert(8'h19, 1'b0, 1'b0);
		`check_eq(crit, 1'b0)
		`check_eq(fan, 8'h40)
		fm_host_model_inst.write_reg(fm_pkg::CMD_WCFG, 8'h02);
		convert(8'h70, 1'b0, 1'b0);
		`check_eq(crit, 1'b1)
		`check_eq(fan, 8'h40)
		$display("test critical_override done");

		// second reset in mid-run: pointer, limits and fault flag back at power-on values
		rstn = 1'b0;
		det = 1'b1;
		repeat (8) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		`check_eq(alert_oe, 1'b0)
		fm_host_model_inst.recv_only(rd);
		`check_eq(rd, 8'h00)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RSTAT, rd);
		`check_eq(rd[2], 1'b0)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RHI, rd);
		`check_eq(rd, fm_pkg::HI_RST)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RLOW, rd);
		`check_eq(rd, fm_pkg::LO_RST)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RCRIT, rd);
		`check_eq(rd, fm_pkg::CRIT_RST)
		fm_host_model_inst.read_reg(fm_pkg::CMD_RCFG, rd);
		`check_eq(rd, fm_pkg::CFG_RST)
		$display("test mid_reset done");
		print_verdict();
	end
endmodule : test_thermal_alert_interrupt_logic
